// ---- core/spm_pkg.sv ----
// Constants, register map and field layout of the serial port block
// How it works
// - As slave, select is input; low select activates, data-out drives only if enabled.
// - Slave select going high resets bit counter and drops partial byte.
// - Master with select as output: select pin is plain output, no effect.
// - Select driven low as master-with-input clears master bit; pins become inputs.
// - That forced fall to slave also sets the completion flag.
// - Control bit 7 enables interrupt with completion flag and global enable.
// - Control bit 6 enables the port; nothing shifts while it is zero.
// - Control bit 5 one sends least significant bit first, else most.
// - Control bit 4 selects master when one, slave when zero.
// - Control bit 3 sets clock idle level and leading edge direction.
// - Control bit 2 zero samples on leading edge, one on trailing edge.
// - Rate bits pick divisor 4,16,64,128 or 2,8,32,64 with double speed.
// - Rate bits have no effect in slave role.
// - Status bit 7 set at completion; cleared by vector or status-then-data access.
// - Status bit 6 set on data write during transfer; cleared by status-then-data access only, not by vector.
// - Status bits 5 to 1 always read zero.
// - Status bit 0 doubles master clock rate; shortest period two clocks.
// - Master data write starts clock, shifts eight bits, stops, sets completion.
// - Send single buffered, receive double buffered; read before next byte ends.
// - Data read returns receive buffer; data write loads shifter and starts.
package spm_pkg;

	// Byte addresses on the bus
	localparam logic [7:0] ADDR_CTRL   = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_DATA   = 8'h08;
	localparam logic [7:0] ADDR_PINCFG = 8'h0C;

	// Control register fields
	localparam int CTRL_IE    = 7;
	localparam int CTRL_EN    = 6;
	localparam int CTRL_ORDER = 5;
	localparam int CTRL_MASTER_ROLE_SELECT  = 4;
	localparam int CTRL_CLOCK_IDLE_POLARITY  = 3;
	localparam int CTRL_CLOCK_SAMPLE_PHASE  = 2;
	localparam int CTRL_RHI   = 1;
	localparam int CTRL_RLO   = 0;

	// Status register fields
	localparam int STAT_DONE = 7;
	localparam int STAT_WRITE_COLLISION_FLAG = 6;
	localparam int STAT_X2   = 0;

	// Pin configuration fields
	localparam int PIN_MOSI_DIR = 0;
	localparam int PIN_MISO_DIR = 1;
	localparam int PIN_SCK_DIR  = 2;
	localparam int PIN_SS_DIR   = 3;
	localparam int PIN_SS_OUT   = 4;

	// Values after reset
	localparam logic [7:0] CTRL_RESET   = 8'h00;
	localparam logic [7:0] PINCFG_RESET = 8'h00;
	localparam logic [7:0] DATA_RESET   = 8'h00;

	// System clock divisors of the master serial clock
	localparam logic [7:0] DIV_N0 = 8'h04;
	localparam logic [7:0] DIV_N1 = 8'h10;
	localparam logic [7:0] DIV_N2 = 8'h40;
	localparam logic [7:0] DIV_N3 = 8'h80;
	localparam logic [7:0] DIV_D0 = 8'h02;
	localparam logic [7:0] DIV_D1 = 8'h08;
	localparam logic [7:0] DIV_D2 = 8'h20;
	localparam logic [7:0] DIV_D3 = 8'h40;

	// Clock edges in one byte, index of the last
	localparam logic [3:0] LAST_EDGE = 4'hF;

endpackage

// ---- core/spm_port.sv ----
// Serial peripheral port, master or slave, with AHB-Lite register access
//
// Design decisions made here: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/1ns
module spm_port
	import spm_pkg::*;
(
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic [31:0]      hrdata,
	output logic             hresp,
	input  wire logic        global_irq_enable,
	input  wire logic        irq_vector_ack,
	output logic             irq_request,
	input  wire logic        sck_in,
	output logic             sck_out,
	output logic             sck_oe,
	input  wire logic        mosi_in,
	output logic             mosi_out,
	output logic             mosi_oe,
	input  wire logic        miso_in,
	output logic             miso_out,
	output logic             miso_oe,
	input  wire logic        ss_n_in,
	output logic             ss_n_out,
	output logic             ss_n_oe
);

	// Half serial clock period in system clocks
	function automatic logic [6:0] half_period(input logic x2, input logic [1:0] code);
		logic [7:0] div;
		div = DIV_N0;
		unique case ({x2, code})
			3'b000: div = DIV_N0;
			3'b001: div = DIV_N1;
			3'b010: div = DIV_N2;
			3'b011: div = DIV_N3;
			3'b100: div = DIV_D0;
			3'b101: div = DIV_D1;
			3'b110: div = DIV_D2;
			3'b111: div = DIV_D3;
		endcase
		return div[7:1];
	endfunction

	logic [7:0] ctrl;
	logic [7:0] pincfg;
	logic       dbl_speed;
	logic       done_flag;
	logic       write_collision_flag_flag;
	logic       clr_armed;
	logic [7:0] rxbuf;
	logic [7:0] shreg;
	logic       out_bit;
	logic [3:0] ecnt;
	logic       busy;
	logic [6:0] div_cnt;
	logic       sck_lvl;
	logic       sck_s1, sck_s2, sck_prev;
	logic       mosi_s1, mosi_s2;
	logic       miso_s1, miso_s2;
	logic       ss_s1, ss_s2;
	logic       ph_valid;
	logic       ph_write;
	logic [7:0] ph_addr;

	logic       en, master_role_select, ss_low, fault, slave_act, in_bit;
	logic [6:0] half;
	logic       m_edge, s_edge, edge_now, sample, done, out_end;
	logic [7:0] next_shreg;
	logic       addr_ok, rd_status, rd_data, wr_data, xfer_active, start, collide;
	logic       data_access;
	logic [1:0] samp_q, last_q;
	logic [7:0] rxsh, next_rxsh;
	logic       rx_tick, rx_last;

	// Two-stage synchronisers for every pin input
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sck_s1  <= 1'b0;
			sck_s2  <= 1'b0;
			sck_prev <= 1'b0;
			mosi_s1 <= 1'b0;
			mosi_s2 <= 1'b0;
			miso_s1 <= 1'b0;
			miso_s2 <= 1'b0;
			ss_s1   <= 1'b1;
			ss_s2   <= 1'b1;
		end else begin
			sck_s1  <= sck_in;
			sck_s2  <= sck_s1;
			sck_prev <= sck_s2;
			mosi_s1 <= mosi_in;
			mosi_s2 <= mosi_s1;
			miso_s1 <= miso_in;
			miso_s2 <= miso_s1;
			ss_s1   <= ss_n_in;
			ss_s2   <= ss_s1;
		end
	end

	// Role, select and fault decode
	assign en        = ctrl[CTRL_EN];
	assign master_role_select      = ctrl[CTRL_MASTER_ROLE_SELECT];
	assign ss_low    = !ss_s2;
	// select low while master with select as input
	assign fault     = en && master_role_select && !pincfg[PIN_SS_DIR] && ss_low;
	// slave active only while select held low
	assign slave_act = en && !master_role_select && ss_low;
	assign in_bit    = master_role_select ? miso_s2 : mosi_s2;

	// divisor only steers the master clock generator
	assign half   = half_period(dbl_speed, {ctrl[CTRL_RHI], ctrl[CTRL_RLO]});
	assign m_edge = busy && (div_cnt == half - 7'h01);
	assign s_edge = slave_act && (sck_s2 != sck_prev);
	assign edge_now = m_edge || s_edge;
	// even edges lead; phase bit picks sampling edge
	assign sample = (!ecnt[0]) ^ ctrl[CTRL_CLOCK_SAMPLE_PHASE];
	assign done   = edge_now && (ecnt == LAST_EDGE);

	assign next_shreg = ctrl[CTRL_ORDER] ? {in_bit, shreg[7:1]} : {shreg[6:0], in_bit};
	assign out_end    = ctrl[CTRL_ORDER] ? shreg[0] : shreg[7];

	// Bus decode, address phase and data phase
	assign addr_ok     = hsel && htrans[1] && hready;
	assign rd_status   = addr_ok && !hwrite && (haddr[7:0] == ADDR_STATUS);
	assign rd_data     = addr_ok && !hwrite && (haddr[7:0] == ADDR_DATA);
	assign wr_data     = ph_valid && ph_write && (ph_addr == ADDR_DATA);
	assign xfer_active = busy || (slave_act && ecnt != 4'h0);
	assign start       = wr_data && !xfer_active && en && master_role_select && !fault;
	assign collide     = wr_data && xfer_active;
	assign data_access = rd_data || wr_data;

	// Latch the address phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ph_valid <= 1'b0;
			ph_write <= 1'b0;
			ph_addr  <= 8'h00;
		end else if (hready) begin
			ph_valid <= hsel && htrans[1];
			ph_write <= hwrite;
			ph_addr  <= haddr[7:0];
		end
	end

	// Zero-wait OKAY responses
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
	end

	// Read data captured at the address phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0;
		end else if (addr_ok && !hwrite) begin
			unique case (haddr[7:0])
				ADDR_CTRL:   hrdata <= {24'h0, ctrl};
				ADDR_STATUS: hrdata <= {24'h0, done_flag, write_collision_flag_flag, 5'h00, dbl_speed};
				// data read returns the receive buffer
				ADDR_DATA:   hrdata <= {24'h0, rxbuf};
				ADDR_PINCFG: hrdata <= {24'h0, pincfg};
				default:     hrdata <= 32'h0;
			endcase
		end
	end

	// Control register; fault overrides a write
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl <= CTRL_RESET;
		end else begin
			if (ph_valid && ph_write && ph_addr == ADDR_CTRL)
				ctrl <= hwdata[7:0];
			// drop to slave on select fault
			if (fault)
				ctrl[CTRL_MASTER_ROLE_SELECT] <= 1'b0;
		end
	end

	// Pin configuration and double speed
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pincfg    <= PINCFG_RESET;
			dbl_speed <= 1'b0;
		end else if (ph_valid && ph_write) begin
			if (ph_addr == ADDR_PINCFG)
				pincfg <= hwdata[7:0];
			// double speed in status bit 0
			if (ph_addr == ADDR_STATUS)
				dbl_speed <= hwdata[STAT_X2];
		end
	end

	// Status read arms the flag clear by a later data access
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			clr_armed <= 1'b0;
		else if (rd_status)
			clr_armed <= done_flag || write_collision_flag_flag;
		else if (data_access)
			clr_armed <= 1'b0;
	end

	// Completion flag, set wins over clear
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			done_flag <= 1'b0;
		end else if (rx_last || fault) begin
			done_flag <= 1'b1;
		// cleared by vector or armed data access
		end else if (irq_vector_ack || (data_access && clr_armed)) begin
			done_flag <= 1'b0;
		end
	end

	// Collision flag, set wins over clear
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			write_collision_flag_flag <= 1'b0;
		// set on collision, cleared by armed access
		end else if (collide) begin
			write_collision_flag_flag <= 1'b1;
		end else if (data_access && clr_armed) begin
			write_collision_flag_flag <= 1'b0;
		end
	end

	// Interrupt request
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			irq_request <= 1'b0;
		else
			irq_request <= ctrl[CTRL_IE] && done_flag && global_irq_enable;
	end

	// Master clock generator state
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			busy <= 1'b0;
		// only an enabled master runs the clock
		end else if (!en || !master_role_select || fault) begin
			busy <= 1'b0;
		end else if (start) begin
			busy <= 1'b1;
		// clock stops after the last edge
		end else if (done && m_edge) begin
			busy <= 1'b0;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			div_cnt <= 7'h00;
		else if (!busy || start || m_edge)
			div_cnt <= 7'h00;
		else
			div_cnt <= div_cnt + 7'h01;
	end

	// clock rests at the idle level and toggles per edge
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			sck_lvl <= 1'b0;
		else if (!busy)
			sck_lvl <= ctrl[CTRL_CLOCK_IDLE_POLARITY];
		else if (m_edge)
			sck_lvl <= !sck_lvl;
	end

	// Edge counter for both roles
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ecnt <= 4'h0;
		// select high resets the slave counter
		end else if (!en || fault || (!master_role_select && !ss_low) || start) begin
			ecnt <= 4'h0;
		end else if (edge_now) begin
			ecnt <= done ? 4'h0 : ecnt + 4'h1;
		end
	end

	// Shift register: loaded by idle write, shifted on sample edges
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			shreg <= DATA_RESET;
		else if (wr_data && !xfer_active)
			shreg <= hwdata[7:0];
		else if (edge_now && sample)
			shreg <= next_shreg;
	end

	// Output bit: first bit on load, next bit on setup edges
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			out_bit <= 1'b0;
		else if (wr_data && !xfer_active)
			out_bit <= ctrl[CTRL_ORDER] ? hwdata[0] : hwdata[7];
		// setup edge presents the next bit
		else if (edge_now && !sample)
			out_bit <= out_end;
		else if (ecnt == 4'h0 && !edge_now)
			out_bit <= out_end;
	end

	// Receive path; master samples wait out the miso synchroniser
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			samp_q <= 2'b00;
			last_q <= 2'b00;
			rxsh   <= DATA_RESET;
		end else begin
			samp_q <= {samp_q[0], m_edge && sample};
			last_q <= {last_q[0], done && m_edge};
			if (rx_tick)
				rxsh <= next_rxsh;
		end
	end

	// Aligned sample and byte end; master completion lands two clocks late
	assign rx_tick   = master_role_select ? samp_q[1] : (s_edge && sample);
	assign rx_last   = master_role_select ? last_q[1] : (done && s_edge);
	assign next_rxsh = ctrl[CTRL_ORDER] ? {in_bit, rxsh[7:1]} : {rxsh[6:0], in_bit};

	// finished byte moves to the receive buffer
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			rxbuf <= DATA_RESET;
		else if (rx_last)
			rxbuf <= rx_tick ? next_rxsh : rxsh;
	end

	// Pin drive enables and select output
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sck_oe   <= 1'b0;
			mosi_oe  <= 1'b0;
			miso_oe  <= 1'b0;
			ss_n_oe  <= 1'b0;
			ss_n_out <= 1'b1;
		end else begin
			// master pins drive only as enabled master
			sck_oe   <= en && master_role_select && !fault && pincfg[PIN_SCK_DIR];
			mosi_oe  <= en && master_role_select && !fault && pincfg[PIN_MOSI_DIR];
			// slave data out only while selected
			miso_oe  <= slave_act && pincfg[PIN_MISO_DIR];
			// select as plain output outside slave role
			ss_n_oe  <= pincfg[PIN_SS_DIR] && !(en && !master_role_select);
			ss_n_out <= pincfg[PIN_SS_OUT];
		end
	end

	assign sck_out  = sck_lvl;
	assign mosi_out = out_bit;
	assign miso_out = out_bit;

	// Cycles since the last master clock toggle
	logic [7:0] hcnt;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			hcnt <= 8'h00;
		else if (!busy || m_edge)
			hcnt <= 8'h00;
		else if (hcnt != 8'hFF)
			hcnt <= hcnt + 8'h01;
	end

	sequence s_fault;
		fault;
	endsequence

	sequence s_fell_slave;
		!ctrl[CTRL_MASTER_ROLE_SELECT] && done_flag && !busy;
	endsequence

	sequence s_collide;
		collide;
	endsequence

	disable_quiet_a: assert property (@(posedge hclk) disable iff (!hresetn)
		!en |=> !sck_oe && !mosi_oe && !miso_oe && !busy)
		else $error("port drives pins while disabled");

	mode_fault_a: assert property (@(posedge hclk) disable iff (!hresetn)
		s_fault |=> s_fell_slave ##1 (!sck_oe && !mosi_oe))
		else $error("select fault did not drop to slave");

	fault_flag_a: assert property (@(posedge hclk) disable iff (!hresetn)
		s_fault |=> done_flag)
		else $error("select fault did not set completion");

	miso_select_a: assert property (@(posedge hclk) disable iff (!hresetn)
		miso_oe |-> $past(ss_low) && !$past(master_role_select))
		else $error("slave data out driven while deselected");

	slave_reset_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(en && !master_role_select && !ss_low) |=> ecnt == 4'h0 && !$rose(done_flag))
		else $error("deselected slave kept its bit count");

	irq_path_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(ctrl[CTRL_IE] && done_flag && global_irq_enable) ##1 1'b1 |-> irq_request)
		else $error("interrupt not requested");

	irq_quiet_a: assert property (@(posedge hclk) disable iff (!hresetn)
		!ctrl[CTRL_IE] |=> !irq_request)
		else $error("interrupt requested while disabled");

	rate_exact_a: assert property (@(posedge hclk) disable iff (!hresetn)
		m_edge |-> hcnt == {1'b0, half} - 8'h01)
		else $error("master clock half period wrong");

	collide_keep_a: assert property (@(posedge hclk) disable iff (!hresetn)
		s_collide |=> write_collision_flag_flag && $stable(busy) && ecnt != 4'h0 || !en)
		else $error("collision not flagged");

	status_zero_a: assert property (@(posedge hclk) disable iff (!hresetn)
		rd_status |=> hrdata[5:1] == 5'h00 && hrdata[7] == $past(done_flag))
		else $error("status read wrong");

	byte_done_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(done && m_edge) |=> (!busy && sck_lvl == ctrl[CTRL_CLOCK_IDLE_POLARITY]) ##2 done_flag)
		else $error("master byte did not finish cleanly");

	rx_keep_a: assert property (@(posedge hclk) disable iff (!hresetn)
		!rx_last |=> $stable(rxbuf))
		else $error("receive buffer changed without a byte");

endmodule

// ---- sim/spm_peer.sv ----
// Far-side serial peripheral model, a slave of the port's master role
`timescale 1ns/1ns
module spm_peer (
	input  wire logic       sck,
	input  wire logic       mosi,
	input  wire logic       clock_sample_phase,
	input  wire logic       lsb,
	output logic            miso,
	output logic [7:0]      rx_byte
);
	logic [7:0] tx = 8'h00;
	int         n  = 16;

	// Position in the byte of serial bit i
	function automatic int pos(input int i);
		return lsb ? i : 7 - i;
	endfunction

	// Load a reply; with phase one the first bit is not yet valid
	task automatic arm(input logic [7:0] b);
		tx = b;
		n = 0;
		rx_byte = 8'h00;
		miso = clock_sample_phase ? ~b[pos(0)] : b[pos(0)];
	endtask

	always @(sck) begin
		if (n < 16) begin
			if (n % 2 == int'(clock_sample_phase)) begin
				rx_byte[pos(n / 2)] = mosi;
			end else if (n < 15) begin
				miso = tx[pos((n + 1) / 2)];
			end
			if (n == 15) begin
				miso = ~miso;
			end
			n++;
		end
	end
endmodule

// ---- sim/test_spm_port.sv ----
// Self-checking bench of the serial port: registers, master, slave, faults
`timescale 1ns/1ns
module test_spm_port
	import spm_pkg::*;
;
	logic        hclk     = 1'b0;
	logic        hresetn  = 1'b0;
	logic        hsel     = 1'b1;
	logic [31:0] haddr    = 32'h00000000;
	logic [1:0]  htrans   = 2'b00;
	logic        hwrite   = 1'b0;
	logic [31:0] hwdata   = 32'h00000000;
	logic        glob_ie  = 1'b0;
	logic        vec_ack  = 1'b0;
	logic        tb_sck   = 1'b0;
	logic        tb_mosi  = 1'b0;
	logic        tb_ss_n  = 1'b1;
	logic        p_clock_sample_phase   = 1'b0;
	logic        p_lsb    = 1'b0;
	logic        sck_q    = 1'b0;
	logic        hreadyout, hresp, irq_request, peer_miso;
	logic        sck_out, sck_oe, mosi_out, mosi_oe, miso_out, miso_oe, ss_n_out, ss_n_oe;
	logic [31:0] hrdata, rd;
	logic [7:0]  peer_rx, got;
	int          n_mismatch = 0;
	int          check_count = 0;
	int          cyc = 0;
	int          t_last = 0;
	int          gap = 0;
	int          n_tog = 0;
	int          t;
	int          divs[8] = '{4, 16, 64, 128, 2, 8, 32, 64};

	// Pin levels from every party's enable
	wire sck_line  = sck_oe ? sck_out : tb_sck;
	wire mosi_line = mosi_oe ? mosi_out : tb_mosi;
	wire miso_line = miso_oe ? miso_out : peer_miso;
	wire ss_n_line = ss_n_oe ? ss_n_out : tb_ss_n;

	// System clock
	always #2 hclk = ~hclk;

	spm_port i_dut (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
		.global_irq_enable(glob_ie), .irq_vector_ack(vec_ack), .irq_request(irq_request),
		.sck_in(sck_line), .sck_out(sck_out), .sck_oe(sck_oe),
		.mosi_in(mosi_line), .mosi_out(mosi_out), .mosi_oe(mosi_oe),
		.miso_in(miso_line), .miso_out(miso_out), .miso_oe(miso_oe),
		.ss_n_in(ss_n_line), .ss_n_out(ss_n_out), .ss_n_oe(ss_n_oe)
	);

	spm_peer i_peer (
		.sck(sck_line), .mosi(mosi_line), .clock_sample_phase(p_clock_sample_phase), .lsb(p_lsb),
		.miso(peer_miso), .rx_byte(peer_rx)
	);

	// Cycle count, serial clock toggle spacing and hang limit
	always @(posedge hclk) begin
		cyc++;
		if (sck_out !== sck_q) begin
			gap = cyc - t_last;
			t_last = cyc;
			n_tog++;
		end
		sck_q = sck_out;
		if (cyc > 40000) begin
			n_mismatch++;
			wrap_up();
		end
	end

	task automatic wrap_up;
		$display("Comparisons %0d, mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic check(input logic [31:0] g, input logic [31:0] e);
		check_count++;
		if (g !== e) begin
			n_mismatch++;
			$display("[FAIL] %0t: got %h, expected %h", $time, g, e);
		end
	endtask

	task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
		haddr <= {24'h000000, a};
		hwrite <= 1'b1;
		htrans <= 2'b10;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hwdata <= {24'h000000, d};
		do @(posedge hclk); while (hreadyout !== 1'b1);
	endtask

	task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
		haddr <= {24'h000000, a};
		hwrite <= 1'b0;
		htrans <= 2'b10;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		d = hrdata;
	endtask

	task automatic rd_expect(input logic [7:0] a, input logic [7:0] e);
		bus_rd(a, rd);
		check(rd, {24'h000000, e});
	endtask

	// Poll status until completion, then compare it whole
	task automatic wait_done(input logic [7:0] e);
		do bus_rd(ADDR_STATUS, rd); while (rd[7] !== 1'b1);
		check(rd, {24'h000000, e});
	endtask

	// One master byte; index picks rate, double speed, mode and order
	task automatic master_xfer(input logic [2:0] i);
		logic [7:0] tx;
		logic [7:0] rx;
		tx = 8'h1D ^ {5'h00, i};
		rx = 8'hB2 ^ {1'b0, i, 4'h0};
		bus_wr(ADDR_STATUS, {7'h00, i[2]});
		bus_wr(ADDR_CTRL, {2'b01, i[2], 1'b1, i[0], i[1], i[1:0]});
		p_clock_sample_phase = i[1];
		p_lsb = i[2];
		repeat (2) @(posedge hclk);
		i_peer.arm(rx);
		check(sck_out, i[0]);
		check({ss_n_oe, ss_n_out}, 2'b11);
		bus_wr(ADDR_DATA, tx);
		wait_done({1'b1, 6'h00, i[2]});
		check(gap, divs[i] / 2);
		check(peer_rx, tx);
		rd_expect(ADDR_DATA, rx);
		rd_expect(ADDR_STATUS, {7'h00, i[2]});
	endtask

	// Outside master, mode zero, most significant bit first
	task automatic ext_xfer(input logic [7:0] b, input int nbits, output logic [7:0] g);
		g = 8'h00;
		tb_ss_n <= 1'b0;
		repeat (10) @(posedge hclk);
		check({miso_oe, mosi_oe, sck_oe}, 3'b100);
		for (int k = 0; k < nbits; k++) begin
			tb_mosi <= b[7 - k];
			repeat (10) @(posedge hclk);
			tb_sck <= 1'b1;
			g[7 - k] = miso_line;
			repeat (10) @(posedge hclk);
			tb_sck <= 1'b0;
		end
		repeat (10) @(posedge hclk);
		tb_ss_n <= 1'b1;
		tb_mosi <= ~tb_mosi;
		repeat (10) @(posedge hclk);
	endtask

	// Main sequence
	initial begin
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rd_expect(ADDR_CTRL, CTRL_RESET);
		check({hreadyout, hresp}, 2'b10);
		rd_expect(ADDR_STATUS, 8'h00);
		rd_expect(ADDR_PINCFG, PINCFG_RESET);
		bus_wr(8'h10, 8'hFF);
		rd_expect(8'h10, 8'h00);
		bus_wr(ADDR_STATUS, 8'hFF);
		rd_expect(ADDR_STATUS, 8'h01);
		bus_wr(ADDR_PINCFG, 8'h1D);
		bus_wr(ADDR_CTRL, 8'h13);
		t = n_tog;
		bus_wr(ADDR_DATA, 8'h55);
		repeat (300) @(posedge hclk);
		check(n_tog, t);
		check(sck_oe, 1'b0);
		rd_expect(ADDR_STATUS, 8'h01);
		for (int i = 0; i < 8; i++) master_xfer(3'(i));
		// Second data write in mid-transfer
		bus_wr(ADDR_STATUS, 8'h00);
		bus_wr(ADDR_CTRL, 8'h50);
		p_clock_sample_phase = 1'b0;
		p_lsb = 1'b0;
		repeat (2) @(posedge hclk);
		i_peer.arm(8'h3A);
		bus_wr(ADDR_DATA, 8'hC6);
		bus_wr(ADDR_DATA, 8'h0F);
		wait_done(8'hC0);
		check(peer_rx, 8'hC6);
		rd_expect(ADDR_DATA, 8'h3A);
		rd_expect(ADDR_STATUS, 8'h00);
		// Interrupt request, global gate and vector acknowledge
		bus_wr(ADDR_CTRL, 8'hD0);
		glob_ie <= 1'b1;
		i_peer.arm(8'h81);
		bus_wr(ADDR_DATA, 8'h7E);
		for (int k = 0; k < 100 && irq_request !== 1'b1; k++) @(posedge hclk);
		check(irq_request, 1'b1);
		glob_ie <= 1'b0;
		repeat (3) @(posedge hclk);
		check(irq_request, 1'b0);
		glob_ie <= 1'b1;
		vec_ack <= 1'b1;
		@(posedge hclk);
		vec_ack <= 1'b0;
		repeat (3) @(posedge hclk);
		check(irq_request, 1'b0);
		rd_expect(ADDR_STATUS, 8'h00);
		rd_expect(ADDR_DATA, 8'h81);
		// Outside select pulls the master down to slave
		bus_wr(ADDR_CTRL, 8'h50);
		bus_wr(ADDR_PINCFG, 8'h05);
		rd_expect(ADDR_CTRL, 8'h50);
		tb_ss_n <= 1'b0;
		repeat (8) @(posedge hclk);
		check({sck_oe, mosi_oe}, 2'b00);
		rd_expect(ADDR_CTRL, 8'h40);
		wait_done(8'h80);
		bus_rd(ADDR_DATA, rd);
		tb_ss_n <= 1'b1;
		bus_wr(ADDR_CTRL, 8'h50);
		rd_expect(ADDR_CTRL, 8'h50);
		// Slave role from outside, after a dropped partial byte
		bus_wr(ADDR_PINCFG, 8'h02);
		bus_wr(ADDR_CTRL, 8'h43);
		ext_xfer(8'hFF, 3, got);
		bus_wr(ADDR_DATA, 8'h6B);
		ext_xfer(8'h4E, 8, got);
		check(got, 8'h6B);
		wait_done(8'h80);
		rd_expect(ADDR_DATA, 8'h4E);
		wrap_up();
	end
endmodule
